/* core/fec_bus_cycle.sv */
// one flash bus cycle, write or read, on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fec_bus_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic wr,
  input wire logic [18:0] addr,
  input wire logic [7:0] wdata,
  // answer
  output logic done,
  output logic [7:0] rdata,
  // flash pins
  output logic [18:0] flash_addr,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  input wire logic [7:0] status_data_lines_in,
  output logic [7:0] status_data_lines_out,
  output logic status_data_lines_oe
);

  typedef struct packed {
    fec_pkg::fec_phase_type phase;
    logic [4:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dout;
    logic doe;
    logic [7:0] rdata;
    logic done;
  } fec_cyc_type;

  fec_cyc_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.phase)
      fec_pkg::PH_IDLE: begin
        if (start) begin
          s_d.phase = fec_pkg::PH_SETUP;
          s_d.wr = wr;
          s_d.addr = addr;
          s_d.dout = wdata;
          s_d.doe = wr;
          s_d.ce_n = 1'b0;
        end
      end
      fec_pkg::PH_SETUP: begin
        s_d.phase = fec_pkg::PH_STROBE;
        s_d.we_n = ~s_q.wr;
        s_d.oe_n = s_q.wr;
        s_d.cnt = s_q.wr ? fec_pkg::WP_CNT : fec_pkg::ACC_CNT;
      end
      fec_pkg::PH_STROBE: begin
        if (s_q.cnt == 5'h00) begin
          // on this rising edge the flash takes write data, or read data is taken into rdata
          s_d.we_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.ce_n = 1'b1;
          if (!s_q.wr) begin
            s_d.rdata = status_data_lines_in;
          end
          s_d.phase = fec_pkg::PH_RECOV;
          s_d.cnt = fec_pkg::RECOV_CNT;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      fec_pkg::PH_RECOV: begin
        if (s_q.cnt == 5'h00) begin
          s_d.doe = 1'b0;
          s_d.phase = fec_pkg::PH_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 5'h01;
        end
      end
      default: begin
        s_d.phase = fec_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{phase: fec_pkg::PH_IDLE, cnt: 5'h00, wr: 1'b0, ce_n: 1'b1,
               oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000, dout: 8'h00,
               doe: 1'b0, rdata: 8'h00, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign rdata = s_q.rdata;
  assign flash_addr = s_q.addr;
  assign chip_enable_n = s_q.ce_n;
  assign output_enable_n = s_q.oe_n;
  assign write_enable_n = s_q.we_n;
  assign status_data_lines_out = s_q.dout;
  assign status_data_lines_oe = s_q.doe;

endmodule
`default_nettype wire

/* core/fec_erase_host.sv */
// host controller issuing flash erase, suspend and resume sequences
`timescale 1ns/1ps
`default_nettype none
module fec_erase_host #(
  parameter int COLLECT_CYC = fec_pkg::COLLECT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output logic [18:0] flash_addr,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic hw_reset_n,
  input wire logic ready_busy_out,
  input wire logic [7:0] status_data_lines_in,
  output logic [7:0] status_data_lines_out,
  output logic status_data_lines_oe
);

  typedef struct packed {
    fec_pkg::fec_mode_type mode;
    fec_pkg::fec_op_type op;
    logic busy;
    logic start;
    logic [2:0] step;
    logic [6:0] sect;
    logic err;
    logic [7:0] poll;
    logic [15:0] tmr;
    logic rst_pin;
    logic [31:0] rdata;
  } fec_host_type;

  fec_host_type s_q, s_d;
  logic eng_done;
  logic [7:0] eng_rdata;
  logic [2:0] req_op;

  // ********************************************
  // sequence tables
  // ********************************************
  function automatic logic [2:0] seq_last(input fec_pkg::fec_op_type op);
    if (op == fec_pkg::OP_CHIP || op == fec_pkg::OP_SECT) begin
      seq_last = fec_pkg::STEP_FINAL;
    end else begin
      seq_last = 3'h0;
    end
  endfunction

  function automatic logic [18:0] seq_addr(input fec_pkg::fec_op_type op,
                                           input logic [2:0] step,
                                           input logic [6:0] sect);
    seq_addr = fec_pkg::ADDR_ANY;
    case (op)
      fec_pkg::OP_CHIP, fec_pkg::OP_SECT: begin
        case (step)
          3'h1, 3'h4: seq_addr = fec_pkg::ADDR_UNLOCK2;
          3'h5: begin
            if (op == fec_pkg::OP_SECT) begin
              seq_addr = {sect, fec_pkg::SECT_LOW};
            end else begin
              seq_addr = fec_pkg::ADDR_UNLOCK1;
            end
          end
          default: seq_addr = fec_pkg::ADDR_UNLOCK1;
        endcase
      end
      fec_pkg::OP_ADD, fec_pkg::OP_POLL: seq_addr = {sect, fec_pkg::SECT_LOW};
      default: seq_addr = fec_pkg::ADDR_ANY;
    endcase
  endfunction

  function automatic logic [7:0] seq_data(input fec_pkg::fec_op_type op,
                                          input logic [2:0] step);
    seq_data = 8'h00;
    case (op)
      fec_pkg::OP_CHIP, fec_pkg::OP_SECT: begin
        case (step)
          3'h0, 3'h3: seq_data = fec_pkg::CMD_UNLOCK1;
          3'h1, 3'h4: seq_data = fec_pkg::CMD_UNLOCK2;
          3'h2: seq_data = fec_pkg::CMD_SETUP;
          default: begin
            if (op == fec_pkg::OP_CHIP) begin
              seq_data = fec_pkg::CMD_CHIP;
            end else begin
              seq_data = fec_pkg::CMD_SECT;
            end
          end
        endcase
      end
      fec_pkg::OP_ADD: seq_data = fec_pkg::CMD_SECT;
      fec_pkg::OP_SUSP: seq_data = fec_pkg::CMD_SUSP;
      fec_pkg::OP_RESUME: seq_data = fec_pkg::CMD_RESUME;
      default: seq_data = 8'h00;
    endcase
  endfunction

  // which orders the flash state allows
  function automatic logic op_ok(input logic [2:0] op,
                                 input fec_pkg::fec_mode_type mode,
                                 input logic [15:0] tmr);
    case (op)
      fec_pkg::OP_CHIP, fec_pkg::OP_SECT:
        op_ok = (mode == fec_pkg::MODE_READ);
      fec_pkg::OP_ADD:
        op_ok = (mode == fec_pkg::MODE_COLLECT) &&
                (tmr < 16'(COLLECT_CYC - fec_pkg::GUARD_CYC));
      fec_pkg::OP_SUSP:
        op_ok = (mode == fec_pkg::MODE_COLLECT) ||
                (mode == fec_pkg::MODE_SECT);
      fec_pkg::OP_RESUME: op_ok = (mode == fec_pkg::MODE_SUSP);
      fec_pkg::OP_POLL: op_ok = (mode != fec_pkg::MODE_HWRST);
      fec_pkg::OP_HWRST: op_ok = 1'b1;
      default: op_ok = 1'b0;
    endcase
  endfunction

  // ********************************************
  // control
  // ********************************************
  assign req_op = reg_wdata[2:0];

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rdata = 32'h00000000;

    // mode timers
    case (s_q.mode)
      fec_pkg::MODE_CHIP, fec_pkg::MODE_SECT: begin
        if (s_q.tmr != 16'h0000) begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end else if (ready_busy_out) begin
          s_d.mode = fec_pkg::MODE_READ;
        end
      end
      fec_pkg::MODE_COLLECT: begin
        if (s_q.tmr >= 16'(COLLECT_CYC - 1)) begin
          s_d.mode = fec_pkg::MODE_SECT;
          s_d.tmr = fec_pkg::BUSY_CNT;
        end else begin
          s_d.tmr = s_q.tmr + 16'h0001;
        end
      end
      fec_pkg::MODE_SUSPENDING: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.mode = fec_pkg::MODE_SUSP;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      fec_pkg::MODE_HWRST: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.rst_pin = 1'b1;
          s_d.mode = fec_pkg::MODE_READ;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      default: begin
        s_d.tmr = s_q.tmr;
      end
    endcase

    // sequence stepping
    if (s_q.busy && eng_done) begin
      if (s_q.step != seq_last(s_q.op)) begin
        s_d.step = s_q.step + 3'h1;
        s_d.start = 1'b1;
      end else begin
        s_d.busy = 1'b0;
        case (s_q.op)
          fec_pkg::OP_CHIP: begin
            s_d.mode = fec_pkg::MODE_CHIP;
            s_d.tmr = fec_pkg::BUSY_CNT;
          end
          fec_pkg::OP_SECT, fec_pkg::OP_ADD: begin
            s_d.mode = fec_pkg::MODE_COLLECT;
            s_d.tmr = 16'h0000;
          end
          fec_pkg::OP_SUSP: begin
            if (s_q.mode == fec_pkg::MODE_COLLECT) begin
              s_d.mode = fec_pkg::MODE_SUSP;
            end else begin
              s_d.mode = fec_pkg::MODE_SUSPENDING;
              s_d.tmr = fec_pkg::SUSP_CNT;
            end
          end
          fec_pkg::OP_RESUME: begin
            s_d.mode = fec_pkg::MODE_SECT;
            s_d.tmr = fec_pkg::BUSY_CNT;
          end
          fec_pkg::OP_POLL: s_d.poll = eng_rdata;
          default: s_d.busy = 1'b0;
        endcase
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        fec_pkg::REG_CTRL: begin
          if (req_op == 3'(fec_pkg::OP_NONE)) begin
            s_d.err = s_q.err;
          end else if (s_q.busy || !op_ok(req_op, s_q.mode, s_q.tmr)) begin
            s_d.err = 1'b1;
          end else if (req_op == 3'(fec_pkg::OP_HWRST)) begin
            s_d.mode = fec_pkg::MODE_HWRST;
            s_d.rst_pin = 1'b0;
            s_d.tmr = fec_pkg::RP_CNT;
          end else begin
            s_d.op = fec_pkg::fec_op_type'(req_op);
            s_d.busy = 1'b1;
            s_d.step = 3'h0;
            s_d.start = 1'b1;
          end
        end
        fec_pkg::REG_SECT: begin
          if (s_q.busy) begin
            s_d.err = 1'b1;
          end else begin
            s_d.sect = reg_wdata[6:0];
          end
        end
        fec_pkg::REG_STAT: s_d.err = 1'b0;
        default: s_d.err = s_q.err;
      endcase
    end

    // register reads
    if (reg_rd) begin
      case (reg_addr)
        fec_pkg::REG_CTRL: s_d.rdata = {29'h00000000, s_q.op};
        fec_pkg::REG_SECT: s_d.rdata = {25'h0000000, s_q.sect};
        fec_pkg::REG_STAT: begin
          s_d.rdata = {25'h0000000, s_q.poll[fec_pkg::TIMER_BIT],
                       ready_busy_out, s_q.err, s_q.busy, s_q.mode};
        end
        fec_pkg::REG_POLL: s_d.rdata = {24'h000000, s_q.poll};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{mode: fec_pkg::MODE_READ, op: fec_pkg::OP_NONE, busy: 1'b0,
               start: 1'b0, step: 3'h0, sect: fec_pkg::RST_SECT, err: 1'b0,
               poll: fec_pkg::RST_POLL, tmr: 16'h0000, rst_pin: 1'b1,
               rdata: 32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************
  // flash bus cycles
  // ********************************************
  fec_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(s_q.start),
    .wr(s_q.op != fec_pkg::OP_POLL),
    .addr(seq_addr(s_q.op, s_q.step, s_q.sect)),
    .wdata(seq_data(s_q.op, s_q.step)),
    .done(eng_done),
    .rdata(eng_rdata),
    .flash_addr(flash_addr),
    .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n),
    .status_data_lines_in(status_data_lines_in),
    .status_data_lines_out(status_data_lines_out),
    .status_data_lines_oe(status_data_lines_oe)
  );

  assign reg_rdata = s_q.rdata;
  assign hw_reset_n = s_q.rst_pin;

endmodule
`default_nettype wire

/* core/fec_pkg.sv */
// constants and types shared by the flash erase host controller
package fec_pkg;

  // ********************************************
  // clock and timing
  // ********************************************
  localparam int CLK_NS = 8;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 120;
  localparam int T_RECOV_NS = 30;
  localparam int T_RP_NS = 500;
  localparam int T_BUSY_NS = 90;
  localparam int T_COLLECT_US = 50;
  localparam int T_SUSP_US = 20;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int COLLECT_CYC = (T_COLLECT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_CYC = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int GUARD_CYC = 64;
  localparam logic [4:0] WP_CNT = 5'(WP_CYC - 1);
  localparam logic [4:0] ACC_CNT = 5'(ACC_CYC - 1);
  localparam logic [4:0] RECOV_CNT = 5'(RECOV_CYC - 1);
  localparam logic [15:0] RP_CNT = 16'(RP_CYC - 1);
  localparam logic [15:0] BUSY_CNT = 16'(BUSY_CYC - 1);
  localparam logic [15:0] SUSP_CNT = 16'(SUSP_CYC - 1);

  // ********************************************
  // register map of the controller
  // ********************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SECT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_POLL = 8'h0c;
  localparam logic [6:0] RST_SECT = 7'h00;
  localparam logic [7:0] RST_POLL = 8'h00;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_ERR_BIT = 4;
  localparam int STAT_RB_BIT = 5;
  localparam int STAT_TIMER_BIT = 6;

  // ********************************************
  // flash command cycles
  // ********************************************
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h002aa;
  localparam logic [18:0] ADDR_ANY = 19'h00000;
  localparam logic [11:0] SECT_LOW = 12'h000;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_SUSP = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [2:0] STEP_FINAL = 3'h5;
  localparam int TIMER_BIT = 3;

  // ********************************************
  // types
  // ********************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_CHIP = 3'h1,
    OP_SECT = 3'h2,
    OP_ADD = 3'h3,
    OP_SUSP = 3'h4,
    OP_RESUME = 3'h5,
    OP_POLL = 3'h6,
    OP_HWRST = 3'h7
  } fec_op_type;

  typedef enum logic [2:0] {
    MODE_READ = 3'h0,
    MODE_CHIP = 3'h1,
    MODE_COLLECT = 3'h2,
    MODE_SECT = 3'h3,
    MODE_SUSPENDING = 3'h4,
    MODE_SUSP = 3'h5,
    MODE_HWRST = 3'h6
  } fec_mode_type;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_STROBE = 2'h2,
    PH_RECOV = 2'h3
  } fec_phase_type;

endpackage

/* tb/fec_erase_host_props.sv */
// checker for flash pin timing of the erase host
`timescale 1ns/1ps
`default_nettype none
module fec_erase_host_props #(
  parameter int COLLECT_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // flash pins
  input wire logic [18:0] flash_addr,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic hw_reset_n,
  input wire logic [7:0] status_data_lines_out,
  input wire logic status_data_lines_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_we_framed: assert property (!write_enable_n |-> !chip_enable_n
    && output_enable_n && status_data_lines_oe)
    else $error("write strobe outside a framed write");
  chk_we_width: assert property ($fell(write_enable_n) |->
    !write_enable_n[*7] ##1 write_enable_n)
    else $error("write strobe width wrong");
  chk_we_hold: assert property (!write_enable_n &&
    $past(!write_enable_n) |-> $stable(flash_addr)
    && $stable(status_data_lines_out))
    else $error("address or data moved during write");
  chk_recover: assert property ($rose(write_enable_n) |->
    chip_enable_n[*4])
    else $error("recovery too short");
  chk_read_len: assert property ($fell(output_enable_n) |->
    !status_data_lines_oe ##14 !output_enable_n ##1 output_enable_n)
    else $error("read strobe width wrong");
  chk_no_clash: assert property (!output_enable_n |->
    !status_data_lines_oe && write_enable_n)
    else $error("data lines driven during read");
  chk_rst_width: assert property ($fell(hw_reset_n) |->
    ##62 !hw_reset_n ##1 hw_reset_n)
    else $error("reset pulse width wrong");
  chk_rst_quiet: assert property (!hw_reset_n |->
    chip_enable_n && write_enable_n)
    else $error("bus active during flash reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind fec_erase_host fec_erase_host_props #(.COLLECT_CYC(COLLECT_CYC))
  u_props (
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_addr(flash_addr), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .hw_reset_n(hw_reset_n), .status_data_lines_out(status_data_lines_out),
  .status_data_lines_oe(status_data_lines_oe));
`default_nettype wire

/* tb/fec_erase_host_tb.sv */
// self-checking bench for the flash erase host controller
`timescale 1ns/1ps
`default_nettype none
module fec_erase_host_tb;
  logic clk, rst_n, reg_wr, reg_rd, rb, dq_oe, ce_n, oe_n, we_n, hr_n;
  logic [7:0] reg_addr, dq_out, fl_q;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [18:0] fa;
  wire [7:0] dq = dq_oe ? dq_out : fl_q;
  int errors = 0;
  int checked = 0;

  fec_erase_host #(.COLLECT_CYC(200)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .hw_reset_n(hr_n), .ready_busy_out(rb), .status_data_lines_in(dq),
    .status_data_lines_out(dq_out), .status_data_lines_oe(dq_oe));
  fec_flash_model #(.WIN(200), .ERASE(300)) model (.clk(clk),
    .hw_reset_n(hr_n), .flash_addr(fa), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .write_enable_n(we_n), .data_in(dq),
    .ready_busy_out(rb), .data_out(fl_q));

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 4000; i++) begin
      rdr(fec_pkg::REG_STAT);
      if ((rd & m) === v) return;
    end
    chk(rd & m, v);
    stop_test();
  endtask
  task automatic op(input logic [2:0] c);
    wr(fec_pkg::REG_CTRL, {29'h0, c});
    repeat (2) @(posedge clk);
    wait_stat(32'h8, 32'h0);
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] v);
    rdr(fec_pkg::REG_STAT);
    chk(rd & m, v);
  endtask
  task automatic chk_log(input int k, input logic [18:0] a,
                         input logic [7:0] d);
    chk({5'h0, model.lg[(model.n - k) % 8]}, {5'h0, a, d});
  endtask

  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_reset();
    stat(32'hffffffff, 32'h20);
    rdr(fec_pkg::REG_SECT);
    chk(rd, 32'h0);
    wr(8'h10, 32'h5a);
    rdr(8'h10);
    chk(rd, 32'h0);
    op(3'h5);
    stat(32'h1f, 32'h10);
    wr(fec_pkg::REG_STAT, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_chip();
    logic [7:0] ed [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h10};
    op(3'h1);
    for (int k = 0; k < 6; k++) begin
      chk_log(6 - k, (k == 1 || k == 4) ? fec_pkg::ADDR_UNLOCK2 :
        fec_pkg::ADDR_UNLOCK1, ed[k]);
    end
    stat(32'h37, 32'h01);
    op(3'h4);
    stat(32'h17, 32'h11);
    chk_log(1, fec_pkg::ADDR_UNLOCK1, fec_pkg::CMD_CHIP);
    wr(fec_pkg::REG_STAT, 32'h0);
    wait_stat(32'h17, 32'h0);
    $display("test chip erase done");
  endtask
  task automatic t_sector();
    wr(fec_pkg::REG_SECT, 32'h05);
    op(3'h2);
    chk_log(1, {7'h05, fec_pkg::SECT_LOW}, fec_pkg::CMD_SECT);
    wr(fec_pkg::REG_SECT, 32'h7f);
    op(3'h3);
    chk_log(1, {7'h7f, fec_pkg::SECT_LOW}, fec_pkg::CMD_SECT);
    op(3'h1);
    stat(32'h17, 32'h12);
    wr(fec_pkg::REG_STAT, 32'h0);
    // late add inside the guard band must be refused
    repeat (150) @(posedge clk);
    op(3'h3);
    stat(32'h17, 32'h12);
    wr(fec_pkg::REG_STAT, 32'h0);
    wait_stat(32'h7, 32'h3);
    wait_stat(32'h7, 32'h0);
    $display("test sector erase done");
  endtask
  task automatic t_suspend();
    wr(fec_pkg::REG_SECT, 32'h02);
    op(3'h2);
    op(3'h4);
    chk_log(1, fec_pkg::ADDR_ANY, fec_pkg::CMD_SUSP);
    stat(32'h7, 32'h5);
    op(3'h6);
    rdr(fec_pkg::REG_POLL);
    chk(rd & 32'h88, 32'h88);
    stat(32'h40, 32'h40);
    op(3'h5);
    chk_log(1, fec_pkg::ADDR_ANY, fec_pkg::CMD_RESUME);
    stat(32'h7, 32'h3);
    op(3'h4);
    stat(32'h7, 32'h4);
    wait_stat(32'h7, 32'h5);
    op(3'h5);
    wait_stat(32'h7, 32'h0);
    $display("test suspend done");
  endtask
  task automatic t_hwrst();
    op(3'h1);
    op(3'h7);
    wait_stat(32'h7, 32'h0);
    chk({31'h0, model.chip}, 32'h0);
    stat(32'h3f, 32'h20);
    $display("test hardware reset done");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_chip();
    t_sector();
    t_suspend();
    t_hwrst();
    stop_test();
  end
endmodule
`default_nettype wire

/* tb/fec_flash_model.sv */
// behavioural flash device answering erase command sequences
`timescale 1ns/1ps
`default_nettype none
module fec_flash_model #(
  parameter int WIN = 200,
  parameter int ERASE = 300
) (
  // timer clock
  input wire logic clk,
  // flash pins
  input wire logic hw_reset_n,
  input wire logic [18:0] flash_addr,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [7:0] data_in,
  output logic ready_busy_out,
  output logic [7:0] data_out
);
  logic [26:0] lg [8];
  int n = 0;
  int cnt = 0;
  logic [2:0] step = 3'h0;
  logic chip = 1'b0;
  logic sect = 1'b0;
  logic susp = 1'b0;
  logic tog = 1'b0;
  logic wq = 1'b1;
  logic oq = 1'b1;
  logic [127:0] sel = '0;
  logic [7:0] last = 8'h00;
  logic busy, win, rd, wr;
  logic [10:0] ea;
  logic [7:0] ed, st;
  always_comb begin
    busy = chip | sect;
    win = sect && cnt > ERASE;
    rd = !output_enable_n && !chip_enable_n;
    wr = !wq && write_enable_n;
    ea = (step == 3'h1 || step == 3'h4) ? 11'h2aa : 11'h555;
    ed = (step == 3'h1 || step == 3'h4) ? 8'h55 : 8'haa;
    ed = (step == 3'h2) ? 8'h80 : ed;
    st = {!busy || susp, tog, 2'h0, busy && !win,
      tog & sel[flash_addr[18:12]], 2'h0};
  end
  assign ready_busy_out = !busy || susp;
  // released lines show the inverse of the last byte
  assign data_out = rd ? st : ~last;
  always @(posedge clk or negedge hw_reset_n) begin
    if (!hw_reset_n) begin
      chip <= 1'b0;
      sect <= 1'b0;
      susp <= 1'b0;
      step <= 3'h0;
      sel <= '0;
    end else begin
      wq <= write_enable_n | chip_enable_n;
      oq <= !rd;
      if (rd) last <= st;
      if (rd && oq && busy) tog <= !tog;
      if (busy && !susp && cnt > 0) cnt <= cnt - 1;
      if (busy && !susp && cnt == 1) begin
        chip <= 1'b0;
        sect <= 1'b0;
        sel <= '0;
      end
      if (wr) begin
        n <= n + 1;
        lg[n % 8] <= {flash_addr, data_in};
        if (chip) begin
        end else if (sect && susp) begin
          if (data_in == fec_pkg::CMD_RESUME) susp <= 1'b0;
        end else if (sect && data_in == fec_pkg::CMD_SUSP) begin
          susp <= 1'b1;
          if (win) cnt <= ERASE;
        end else if (win && data_in == fec_pkg::CMD_SECT) begin
          sel[flash_addr[18:12]] <= 1'b1;
          cnt <= WIN + ERASE;
        end else if (win) begin
          sect <= 1'b0;
          sel <= '0;
        end else if (sect) begin
        end else if (step == 3'h5) begin
          chip <= data_in == fec_pkg::CMD_CHIP;
          sect <= data_in == fec_pkg::CMD_SECT;
          if (data_in == fec_pkg::CMD_SECT) sel[flash_addr[18:12]] <= 1'b1;
          cnt <= (data_in == fec_pkg::CMD_SECT) ? WIN + ERASE : ERASE;
          step <= 3'h0;
        end else if (flash_addr[10:0] == ea && data_in == ed) begin
          step <= step + 3'h1;
        end else begin
          step <= 3'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire
